// ---- lrta_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lrta_cfg.svh"

// Operation
// - Low result byte holds mantissa bits 3..0
// - Result is 4-bit exponent, 8-bit mantissa
// - Exponent 15 marks an overload reading
// - Freeze results from start until stop
// - Upper level low nibble forced to fifteen
// - Lower level low nibble is zero
// - Above upper level past delay raises alert
// - Below lower level past delay raises alert
// - No alert unless enable bit set
// - Delay equals register times 100 ms
// - Zero delay alerts on first crossing
// - Status read or disable clears alert flag
// - Enable register bit 0 enables alerts
// - Alert pin open-drain, pulls low when pending
// - Auto mode divides current above 700 lux
// - Auto mode lengthens window as light drops
// - Manual mode uses user divide and window
// - Resolution scales with range in auto
// - Divide and window bits writable only manual
// - Sample every 800 ms unless free running
// - Manual windows 800 ms down to 6.25 ms
module lrta_core #(
  parameter int unsigned STEP_CYCLES = `LRTA_STEP_NS / `LRTA_CLK_NS
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             alert_out,
  output logic             alert_oe_out,
  input  wire logic [15:0] raw_count_in,
  output logic             window_active_out,
  output logic             current_divide_select_out,
  output logic [2:0]       window_length_code_out
);

  lrta_pkg::lrta_state_t s_q;  // Registered state
  lrta_pkg::lrta_state_t s_d;  // Next state

  // Decoded pin events
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        sda_v;
  // Timing
  logic        step;
  logic        step100;
  logic [7:0]  win_steps;
  logic [7:0]  period;
  logic        conv;
  // Conversion path
  logic [4:0]  shift;
  logic [25:0] full;
  logic [3:0]  exp_new;
  logic [7:0]  mant_new;
  logic [25:0] upper_val;
  logic [25:0] lower_val;
  logic        above;
  logic        below;
  logic [7:0]  rd_byte;
  logic        wr_en;
  logic        rd_load;

  // Read mux, reserved bits read zero
  function automatic logic [7:0] rd_mux(input lrta_pkg::lrta_state_t s);
    logic [7:0] r;
    r = 8'h00;
    case (s.ptr)
      `LRTA_OFS_STATUS: r = {7'h00, s.alert_flag};
      `LRTA_OFS_ENABLE: r = {7'h00, s.alert_enable};
      `LRTA_OFS_CONFIG: r = {s.free_running_sampling, s.manual, 2'b00,
                             s.current_divide_select,
                             s.window_length_code};
      `LRTA_OFS_LUX_HI: r = s.lux[11:4];
      `LRTA_OFS_LUX_LO: r = {4'h0, s.lux[3:0]};
      `LRTA_OFS_UPPER:  r = s.upper;
      `LRTA_OFS_LOWER:  r = s.lower;
      `LRTA_OFS_DELAY:  r = s.delay;
      default:          r = 8'h00;
    endcase
    return r;
  endfunction

  // Edge and condition detection on synchronised pins
  always_comb begin
    // Stage 1 feeds only stage 2; logic reads stages 2 and 3
    sda_v     = s_q.sda_sync[1];
    scl_rise  = s_q.scl_sync[1] & ~s_q.scl_sync[2];
    scl_fall  = ~s_q.scl_sync[1] & s_q.scl_sync[2];
    bus_start = s_q.scl_sync[1] & s_q.scl_sync[2] &
                ~s_q.sda_sync[1] & s_q.sda_sync[2];
    bus_stop  = s_q.scl_sync[1] & s_q.scl_sync[2] &
                s_q.sda_sync[1] & ~s_q.sda_sync[2];
  end

  // Measurement timing and encoding of a fresh result
  always_comb begin
    step      = (s_q.step_cnt == STEP_CYCLES - 1);
    step100   = step & (s_q.ms100_cnt == `LRTA_STEPS_100MS);
    win_steps = `LRTA_STEPS_800MS >> s_q.window_length_code;
    // Free running restarts right after the window ends
    period    = s_q.free_running_sampling ? win_steps
                                          : `LRTA_STEPS_800MS;
    conv      = step & (s_q.meas_cnt == win_steps - 8'h01);
    // Scale raw count to 0.045 lux units
    shift     = {2'b00, s_q.window_length_code} +
                (s_q.current_divide_select ? `LRTA_DIV_SHIFT : 5'h00);
    full      = {10'h000, raw_count_in} << shift;
    exp_new   = `LRTA_EXP_OVER;
    mant_new  = 8'hff;
    // Smallest exponent that fits the mantissa in eight bits
    for (int e = 14; e >= 0; e--) begin
      if ((full >> e) < 26'h0000100) begin
        exp_new  = 4'(e);
        mant_new = 8'(full >> e);
      end
    end
    upper_val = {18'h00000, s_q.upper[3:0],
                 `LRTA_UPPER_LOW_NIB} << s_q.upper[7:4];
    lower_val = {18'h00000, s_q.lower[3:0], 4'h0}
                << s_q.lower[7:4];
    // Overload always counts as above the window
    above     = (exp_new == `LRTA_EXP_OVER) |
                ({exp_new, mant_new} != 12'h000 &&
                 ({18'h00000, mant_new} << exp_new) > upper_val);
    below     = (exp_new != `LRTA_EXP_OVER) &&
                (({18'h00000, mant_new} << exp_new) < lower_val);
  end

  // Next-state logic
  always_comb begin
    s_d      = s_q;
    rd_byte  = rd_mux(s_q);
    wr_en    = 1'b0;
    rd_load  = 1'b0;
    s_d.scl_sync = {s_q.scl_sync[1:0], scl_in};
    s_d.sda_sync = {s_q.sda_sync[1:0], sda_in};
    s_d.sda_lvl  = 1'b0;

    // Base step and 100 ms divider
    s_d.step_cnt = step ? 32'h0 : s_q.step_cnt + 32'h1;
    if (step) begin
      s_d.ms100_cnt = s_q.ms100_cnt + 4'h1;
      s_d.meas_cnt  = (s_q.meas_cnt >= period - 8'h01) ? 8'h00
                      : s_q.meas_cnt + 8'h01;
    end
    s_d.win_active = (s_d.meas_cnt < win_steps);

    // Persistence count runs only while outside the window
    if (step100 && s_q.outside && s_q.pers_cnt != 8'hff) begin
      s_d.pers_cnt = s_q.pers_cnt + 8'h01;
    end

    // Completed conversion
    if (conv) begin
      if (s_q.freeze) begin
        s_d.pend   = {exp_new, mant_new};
        s_d.pend_v = 1'b1;
      end else begin
        s_d.lux    = {exp_new, mant_new};
      end
      s_d.outside = above | below;
      if (!(above | below)) begin
        s_d.pers_cnt = 8'h00;
      end
      if (!s_q.outside && (above | below)) begin
        s_d.pers_cnt = 8'h00;
      end
      // Zero delay trips at once; otherwise the time must have passed
      if (s_q.alert_enable && (above | below) &&
          (s_q.delay == 8'h00 ||
           (s_q.outside && s_q.pers_cnt >= s_q.delay))) begin
        s_d.alert_flag = 1'b1;
      end
      // Autoranging picks divide and window from the level
      if (!s_q.manual) begin
        s_d.current_divide_select = (full > `LRTA_AUTO_DIV_CNT);
        if (full < `LRTA_AUTO_T400_CNT) begin
          s_d.window_length_code = 3'h0;
        end else if (full < `LRTA_AUTO_T200_CNT) begin
          s_d.window_length_code = 3'h1;
        end else if (full < `LRTA_AUTO_T100_CNT) begin
          s_d.window_length_code = 3'h2;
        end else begin
          s_d.window_length_code = 3'h3;
        end
      end
    end

    // Serial slave
    if (scl_rise) begin
      case (s_q.st)
        lrta_pkg::LRTA_ADDR, lrta_pkg::LRTA_PTR, lrta_pkg::LRTA_DATA: begin
          s_d.shreg   = {s_q.shreg[6:0], sda_v};
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end
        lrta_pkg::LRTA_READ: s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        lrta_pkg::LRTA_MACK: s_d.nack = sda_v;
        default: ;
      endcase
    end
    if (scl_fall) begin
      case (s_q.st)
        lrta_pkg::LRTA_ADDR: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d.bit_cnt = 4'h0;
            if (s_q.shreg[7:1] == `LRTA_SLAVE_ADDR) begin
              s_d.st        = lrta_pkg::LRTA_ACK;
              s_d.sda_oe    = 1'b1;
              s_d.after_ack = s_q.shreg[0] ? lrta_pkg::LRTA_READ
                                           : lrta_pkg::LRTA_PTR;
            end else begin
              s_d.st = lrta_pkg::LRTA_IDLE;
            end
          end
        end
        lrta_pkg::LRTA_PTR: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d.ptr       = s_q.shreg;
            s_d.bit_cnt   = 4'h0;
            s_d.st        = lrta_pkg::LRTA_ACK;
            s_d.sda_oe    = 1'b1;
            s_d.after_ack = lrta_pkg::LRTA_DATA;
          end
        end
        lrta_pkg::LRTA_DATA: begin
          if (s_q.bit_cnt == 4'h8) begin
            wr_en         = 1'b1;
            s_d.ptr       = s_q.ptr + 8'h01;
            s_d.bit_cnt   = 4'h0;
            s_d.st        = lrta_pkg::LRTA_ACK;
            s_d.sda_oe    = 1'b1;
            s_d.after_ack = lrta_pkg::LRTA_DATA;
          end
        end
        lrta_pkg::LRTA_ACK: begin
          s_d.sda_oe = 1'b0;
          s_d.st     = s_q.after_ack;
          rd_load    = (s_q.after_ack == lrta_pkg::LRTA_READ);
        end
        lrta_pkg::LRTA_READ: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d.sda_oe = 1'b0;
            s_d.st     = lrta_pkg::LRTA_MACK;
          end else begin
            s_d.shreg  = {s_q.shreg[6:0], 1'b0};
            s_d.sda_oe = ~s_q.shreg[6];
          end
        end
        lrta_pkg::LRTA_MACK: begin
          // Master nack ends the read; stop is awaited in idle
          if (s_q.nack) begin
            s_d.st = lrta_pkg::LRTA_IDLE;
          end else begin
            s_d.st  = lrta_pkg::LRTA_READ;
            rd_load = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Load a read byte and drive its top bit
    if (rd_load) begin
      s_d.shreg   = rd_byte;
      s_d.sda_oe  = ~rd_byte[7];
      s_d.bit_cnt = 4'h0;
      s_d.ptr     = s_q.ptr + 8'h01;
    end
    // Register writes
    if (wr_en) begin
      case (s_q.ptr)
        `LRTA_OFS_ENABLE: s_d.alert_enable = s_q.shreg[0];
        `LRTA_OFS_CONFIG: begin
          s_d.free_running_sampling = s_q.shreg[`LRTA_CFG_FREE_BIT];
          s_d.manual = s_q.shreg[`LRTA_CFG_MANUAL_BIT];
          if (s_q.shreg[`LRTA_CFG_MANUAL_BIT]) begin
            s_d.current_divide_select =
              s_q.shreg[`LRTA_CFG_DIV_BIT];
            s_d.window_length_code = s_q.shreg[2:0];
          end
        end
        `LRTA_OFS_UPPER: s_d.upper = s_q.shreg;
        `LRTA_OFS_LOWER: s_d.lower = s_q.shreg;
        `LRTA_OFS_DELAY: s_d.delay = s_q.shreg;
        default: ;
      endcase
    end
    // Flag clears; a trip in the same cycle still wins over a status read
    if ((rd_load && s_q.ptr == `LRTA_OFS_STATUS) ||
        (wr_en && s_q.ptr == `LRTA_OFS_ENABLE && !s_q.shreg[0])) begin
      s_d.alert_flag = 1'b0;
      if (conv && s_q.alert_enable && (above | below) &&
          (s_q.delay == 8'h00 ||
           (s_q.outside && s_q.pers_cnt >= s_q.delay))) begin
        s_d.alert_flag = 1'b1;
      end
    end
    if (!s_d.alert_enable) begin
      s_d.alert_flag = 1'b0;
    end

    // Start and stop override the bit machine
    if (bus_start) begin
      s_d.st      = lrta_pkg::LRTA_ADDR;
      s_d.bit_cnt = 4'h0;
      s_d.sda_oe  = 1'b0;
      s_d.freeze  = 1'b1;
    end else if (bus_stop) begin
      s_d.st      = lrta_pkg::LRTA_IDLE;
      s_d.sda_oe  = 1'b0;
      s_d.freeze  = 1'b0;
      if (s_d.pend_v) begin
        s_d.lux    = s_d.pend;
        s_d.pend_v = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q                       <= '0;
      s_q.scl_sync              <= 3'h7;
      s_q.sda_sync              <= 3'h7;
      s_q.st                    <= lrta_pkg::LRTA_IDLE;
      s_q.after_ack             <= lrta_pkg::LRTA_IDLE;
      s_q.free_running_sampling <= 1'(`LRTA_RST_CONFIG >> `LRTA_CFG_FREE_BIT);
      s_q.manual                <=
        1'(`LRTA_RST_CONFIG >> `LRTA_CFG_MANUAL_BIT);
      s_q.current_divide_select <= 1'(`LRTA_RST_CONFIG >> `LRTA_CFG_DIV_BIT);
      s_q.window_length_code    <= 3'(`LRTA_RST_CONFIG);
      s_q.upper                 <= `LRTA_RST_UPPER;
      s_q.lower                 <= `LRTA_RST_LOWER;
      s_q.delay                 <= `LRTA_RST_DELAY;
      s_q.win_active            <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  always_comb begin
    sda_out                   = s_q.sda_lvl;
    sda_oe_out                = s_q.sda_oe;
    alert_out                 = s_q.sda_lvl;
    alert_oe_out              = s_q.alert_flag;
    window_active_out         = s_q.win_active;
    current_divide_select_out = s_q.current_divide_select;
    window_length_code_out    = s_q.window_length_code;
  end

endmodule
`default_nettype wire

// ---- lrta_cfg.svh ----
`ifndef LRTA_CFG_SVH
`define LRTA_CFG_SVH

// Register offsets
`define LRTA_OFS_STATUS      8'h00
`define LRTA_OFS_ENABLE      8'h01
`define LRTA_OFS_CONFIG      8'h02
`define LRTA_OFS_LUX_HI      8'h03
`define LRTA_OFS_LUX_LO      8'h04
`define LRTA_OFS_UPPER       8'h05
`define LRTA_OFS_LOWER       8'h06
`define LRTA_OFS_DELAY       8'h07

// Config field positions
`define LRTA_CFG_FREE_BIT    7
`define LRTA_CFG_MANUAL_BIT  6
`define LRTA_CFG_DIV_BIT     3

// Reset values
`define LRTA_RST_CONFIG      8'h03
`define LRTA_RST_UPPER       8'hff
`define LRTA_RST_LOWER       8'h00
`define LRTA_RST_DELAY       8'hff

// Serial slave address, 7 bits
`define LRTA_SLAVE_ADDR      7'h4a

// Timing: base step 6.25 ms, clock period 40 ns
`define LRTA_STEP_NS         6250000
`define LRTA_CLK_NS          40
`define LRTA_STEPS_100MS     4'hf
`define LRTA_STEPS_800MS     8'h80

// Encoding limits
`define LRTA_EXP_MAX         4'he
`define LRTA_EXP_OVER        4'hf
`define LRTA_UPPER_LOW_NIB   4'hf
`define LRTA_DIV_SHIFT       5'h03
`define LRTA_AUTO_DIV_CNT    26'h0003cc3
`define LRTA_AUTO_T400_CNT   26'h0000800
`define LRTA_AUTO_T200_CNT   26'h0001000
`define LRTA_AUTO_T100_CNT   26'h0002000

`endif

// ---- lrta_pkg.sv ----
package lrta_pkg;

  // Serial slave phases
  typedef enum logic [2:0] {
    LRTA_IDLE,
    LRTA_ADDR,
    LRTA_PTR,
    LRTA_DATA,
    LRTA_ACK,
    LRTA_READ,
    LRTA_MACK
  } lrta_bus_st_t;

  // Whole state of the block
  typedef struct packed {
    logic [2:0]   scl_sync;   // Clock pin synchroniser and history
    logic [2:0]   sda_sync;   // Data pin synchroniser and history
    lrta_bus_st_t st;         // Serial phase
    lrta_bus_st_t after_ack;  // Phase following the slave ack
    logic [3:0]   bit_cnt;    // Bits seen in this byte
    logic [7:0]   shreg;      // Byte shifter
    logic [7:0]   ptr;        // Register pointer
    logic         nack;       // Master declined more data
    logic         sda_oe;     // Data pin pull-down
    logic         sda_lvl;    // Level driven when enabled
    logic         freeze;     // Result update held off
    logic         pend_v;     // A held result waits
    logic [11:0]  pend;       // Held result
    logic [11:0]  lux;        // Visible result
    logic         alert_flag;
    logic         alert_enable;
    logic         free_running_sampling;
    logic         manual;
    logic         current_divide_select;
    logic [2:0]   window_length_code;
    logic [7:0]   upper;
    logic [7:0]   lower;
    logic [7:0]   delay;
    logic [31:0]  step_cnt;   // Cycles inside a 6.25 ms step
    logic [7:0]   meas_cnt;   // Steps into the measurement period
    logic [3:0]   ms100_cnt;  // Steps inside 100 ms
    logic         outside;    // Last reading outside the window
    logic [7:0]   pers_cnt;   // 100 ms units spent outside
    logic         win_active;
  } lrta_state_t;

endpackage

// ---- lrta_core_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks on the light sensor core
module lrta_core_monitor #(
  parameter int unsigned STEP_CYCLES = 4 // Cycles in one base step
) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_out,
  input wire logic        alert_out,
  input wire logic        alert_oe_out,
  input wire logic [15:0] raw_count_in,
  input wire logic        window_active_out,
  input wire logic        current_divide_select_out,
  input wire logic [2:0]  window_length_code_out
);
  logic scl_q;  // Clock pin one cycle ago
  logic sda_q;  // Data pin one cycle ago
  logic busy_q; // Inside a frame
  logic rst_seen_q = 1'b0; // Reset seen at the previous edge
  // Reset check waits one edge, until the core has taken its reset
  always @(posedge clk_in) begin
    rst_seen_q <= rst_in;
  end
  // Frame tracking on raw pins, ahead of the core's synchroniser
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (scl_q && scl_in && sda_q && !sda_in) begin // Start
        busy_q <= 1'b1;
      end else if (scl_q && scl_in && !sda_q && sda_in) begin // Stop
        busy_q <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_alert_pin_low: assert property (alert_out == 1'b0)
    else $error("alert pin drive level not low");
  a_data_pin_low: assert property (sda_out == 1'b0)
    else $error("data pin drive level not low");
  // Reset state is checked while reset is held, so no disable here
  a_reset_state: assert property (
    @(posedge clk_in) disable iff (1'b0)
    rst_in && rst_seen_q |-> !alert_oe_out && !sda_oe_out &&
    window_active_out && window_length_code_out == 3'h3 &&
    !current_divide_select_out)
    else $error("outputs wrong during reset");
  a_alert_clear_frame: assert property ($fell(alert_oe_out) |-> busy_q)
    else $error("alert cleared outside a bus frame");
  a_alert_holds: assert property ($rose(alert_oe_out) |=> alert_oe_out[*2])
    else $error("alert dropped right after rising");
  a_idle_released: assert property (!busy_q && !$past(busy_q, 4) |-> !sda_oe_out)
    else $error("data pin driven on an idle bus");
  a_drive_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data drive changed while bus clock high");
  a_drive_lasts: assert property ($rose(sda_oe_out) |-> sda_oe_out[*4])
    else $error("data drive too short");
endmodule

bind lrta_core lrta_core_monitor #(.STEP_CYCLES(STEP_CYCLES)) i_mon (
  .clk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .alert_out,
  .alert_oe_out, .raw_count_in, .window_active_out,
  .current_divide_select_out, .window_length_code_out);
`default_nettype wire

// ---- lrta_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-wire bus master in the host's place; clock stands still off frames
module lrta_host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // Idle bus: clock high, data released
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Quarter of a 320 ns bus bit
  task q;
    repeat (2) @(posedge clk_in);
  endtask
  // Start or repeated start; extra wait lets the core release data first
  task start;
    q;
    q;
    sda_low_out <= 1'b0;
    q;
    scl_out <= 1'b1;
    q;
    sda_low_out <= 1'b1;
    q;
    scl_out <= 1'b0;
  endtask
  // Stop: data rises while clock high
  task stop;
    q;
    sda_low_out <= 1'b1;
    q;
    scl_out <= 1'b1;
    q;
    sda_low_out <= 1'b0;
    q;
  endtask
  // Eight bits then a ninth; returns what the wire showed
  task xfer(input logic [7:0] d, input logic nine,
            output logic [7:0] got, output logic ack);
    logic [8:0] v;
    v = {d, nine};
    for (int i = 8; i >= 0; i--) begin
      q;
      sda_low_out <= !v[i];
      q;
      scl_out <= 1'b1;
      q;
      if (i > 0) got[i-1] = sda_in;
      else ack = sda_in;
      q;
      scl_out <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- test_light_result_and_threshold_alert.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_light_result_and_threshold_alert;
  logic        clk_in = 1'b0;     // Core clock
  logic        rst_in = 1'b1;     // Async reset
  logic [15:0] raw_q = 16'h0000;  // Converter count
  logic        scl;               // Bus clock from host
  logic        host_low;          // Host pulls data low
  logic        sda_oe;            // Core pulls data low
  logic        alert_oe;          // Alert pin pulled low
  logic        div;               // Active divide select
  logic [2:0]  code;              // Active window code
  logic [7:0]  b0;                // First byte read
  logic [7:0]  b1;                // Second byte read
  logic        ak;                // Ninth bit seen
  logic        wact_pin;          // Integration window open
  int          wact = 0;          // Window-open cycles counted
  int          errors = 0;        // Mismatches
  int          tests_run = 0;     // Comparisons
  logic [15:0] vals [4] = '{16'h001f, 16'h0020, 16'h0010, 16'h000f};
  logic        trips [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  wire logic   sda = !(sda_oe || host_low); // Pull-up resolves the wire

  lrta_core #(.STEP_CYCLES(4)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_out(sda_oe), .alert_out(),
    .alert_oe_out(alert_oe), .raw_count_in(raw_q),
    .window_active_out(wact_pin),
    .current_divide_select_out(div), .window_length_code_out(code));
  lrta_host_model i_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(host_low));

  // 25 MHz clock
  always #20 clk_in = !clk_in;

  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register write, last ack covers the whole frame
  task wr(input logic [7:0] p, input logic [7:0] d);
    i_host.start();
    i_host.xfer(8'h94, 1'b1, b0, ak);
    i_host.xfer(p, 1'b1, b0, ak);
    i_host.xfer(d, 1'b1, b0, ak);
    chk("write ack", {7'h00, ak}, 8'h00);
    i_host.stop();
  endtask
  // Two-byte read; gap holds the bus between pointer and data
  task rd2(input logic [7:0] p, input int gap);
    i_host.start();
    i_host.xfer(8'h94, 1'b1, b0, ak);
    i_host.xfer(p, 1'b1, b0, ak);
    repeat (gap) @(posedge clk_in);
    i_host.start();
    i_host.xfer(8'h95, 1'b1, b0, ak);
    chk("read ack", {7'h00, ak}, 8'h00);
    i_host.xfer(8'hff, 1'b0, b0, ak);
    i_host.xfer(8'hff, 1'b1, b1, ak);
    i_host.stop();
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Run is about 25k cycles; allow plenty
  initial begin
    #3000000;
    errors++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd2(8'h01, 0);
    chk("enable", b0, 8'h00);
    // Dark auto ranging has already picked the longest window, no divide
    chk("config", b1, 8'h00);
    rd2(8'h05, 0);
    chk("upper", b0, 8'hff);
    chk("lower", b1, 8'h00);
    rd2(8'h07, 0);
    chk("delay", b0, 8'hff);
    chk("unmapped", b1, 8'h00);
    i_host.start();
    i_host.xfer(8'h96, 1'b1, b0, ak);
    chk("foreign ack", {7'h00, ak}, 8'h01);
    i_host.stop();
    $display("test registers done");
    // Largest divide and shortest window push the result to overload
    raw_q <= 16'hffff;
    // Bright light in auto mode: divide on, shortest auto window
    repeat (1100) @(posedge clk_in);
    chk("auto code", {5'h00, code}, 8'h03);
    chk("auto divide", {7'h00, div}, 8'h01);
    wr(8'h02, 8'h4f);
    repeat (1100) @(posedge clk_in);
    chk("code", {5'h00, code}, 8'h07);
    chk("divide", {7'h00, div}, 8'h01);
    // One base step of four cycles open in each 512-cycle period
    repeat (512) begin
      @(posedge clk_in);
      if (wact_pin === 1'b1) wact++;
    end
    chk("window steps", 8'(wact), 8'h04);
    rd2(8'h03, 0);
    chk("overload", {4'h0, b0[7:4]}, 8'h0f);
    raw_q <= 16'h0a5c;
    wr(8'h02, 8'h40);
    repeat (1100) @(posedge clk_in);
    rd2(8'h03, 0);
    chk("lux high", b0, 8'h4a);
    chk("lux low", b1, 8'h05);
    // Count changes while the bus is held open
    fork
      rd2(8'h03, 1200);
      begin
        repeat (200) @(posedge clk_in);
        raw_q <= 16'h0010;
      end
    join
    chk("held high", b0, 8'h4a);
    chk("held low", b1, 8'h05);
    repeat (1100) @(posedge clk_in);
    rd2(8'h03, 0);
    chk("new high", b0, 8'h01);
    chk("new low", b1, 8'h00);
    $display("test result done");
    // Trip levels 31 and 16, readings on both sides of each
    wr(8'h07, 8'h00);
    wr(8'h05, 8'h01);
    wr(8'h06, 8'h01);
    wr(8'h01, 8'h01);
    foreach (vals[i]) begin
      raw_q <= vals[i];
      repeat (1100) @(posedge clk_in);
      chk("alert pin", {7'h00, alert_oe}, {7'h00, trips[i]});
      raw_q <= 16'h0018;
      repeat (600) @(posedge clk_in);
      rd2(8'h00, 0);
      chk("status", b0, {7'h00, trips[i]});
      chk("alert cleared", {7'h00, alert_oe}, 8'h00);
    end
    $display("test thresholds done");
    raw_q <= 16'h0040;
    repeat (1100) @(posedge clk_in);
    chk("alert on", {7'h00, alert_oe}, 8'h01);
    wr(8'h01, 8'h00);
    chk("alert off", {7'h00, alert_oe}, 8'h00);
    repeat (1100) @(posedge clk_in);
    chk("alert masked", {7'h00, alert_oe}, 8'h00);
    // Delay of 900 ms outlasts one 800 ms period but not two
    raw_q <= 16'h0018;
    wr(8'h07, 8'h09);
    wr(8'h01, 8'h01);
    repeat (600) @(posedge clk_in);
    raw_q <= 16'h0040;
    repeat (1000) @(posedge clk_in);
    chk("alert early", {7'h00, alert_oe}, 8'h00);
    repeat (600) @(posedge clk_in);
    chk("alert late", {7'h00, alert_oe}, 8'h01);
    $display("test alerts done");
    // Free running converts every window, so a new count shows at once
    wr(8'h02, 8'hc7);
    raw_q <= 16'h0010;
    repeat (20) @(posedge clk_in);
    rd2(8'h03, 0);
    chk("free high", b0, 8'h48);
    chk("free low", b1, 8'h00);
    $display("test free running done");
    wrap_up();
  end
endmodule
`default_nettype wire
